/* src/sctic_top.v */
// second core trap and interrupt control block with its ahb-lite register slave
// Operation
// - latency select bit 15 of control word: 1 variable, 0 fixed latency.
// - priority msb is 1 when priority level exceeds 7, else 0.
// - four-bit priority level is msb above status word bits 7 to 5.
// - priority msb reads, clears by writing zero, never set by write; resets 0.
// - nesting block bit 15 of trap control 1 stops interrupt nesting.
// - ordinary overflow trap of accumulator a or b sets bit 14 or 13.
// - catastrophic overflow trap of accumulator a or b sets bit 12 or 11.
// - accumulator a or b overflow traps only when enable bit 10 or 9 set.
// - catastrophic overflow traps only while shared enable bit 8 is set.
// - invalid accumulator shift math trap sets bit 7.
// - divide by zero math trap sets bit 6.
// - any math error trap sets bit 4.
// - address error trap sets bit 3, stack error trap sets bit 2.
// - oscillator failure trap sets bit 1 of trap control 1.
// - global enable bit 15 gates interrupts, never traps; resets to 1.
// - bit 14 of control 2 shows a timed interrupt disable in effect.
// - bit 13 of control 2 enables the software trap.
// - polarity bits 0 to 3: 1 falling edge, 0 rising edge detected.
// - nonvolatile memory address soft trap sets bit 8 of soft status.
// - dma address soft trap sets bit 5 of soft status.
// - loop stack overflow soft trap sets bit 4 of soft status.
// - auxiliary pll lock loss soft trap sets bit 0 of soft status.
// - software hard trap sets bit 0 of hard status; other bits read zero.
`timescale 1ns/1ps
`include "sctic_map.vh"

module sctic_top (
   // clock and reset
   input wire mclk,
   input wire nrst,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // trap events from the core, one-cycle pulses
   input wire ev_acc_a_ovf,
   input wire ev_acc_b_ovf,
   input wire ev_acc_a_cat,
   input wire ev_acc_b_cat,
   input wire ev_shift_err,
   input wire ev_div_zero,
   input wire ev_addr_err,
   input wire ev_stack_err,
   input wire ev_osc_fail,
   // soft and software hard trap events, one-cycle pulses
   input wire ev_nvm_addr,
   input wire ev_dma_addr,
   input wire ev_loop_ovf,
   input wire ev_aux_lock_loss,
   input wire ev_sw_hard_trap,
   // core priority level load and timed disable state
   input wire ipl_load,
   input wire [3:0] ipl_new,
   input wire timed_disable_in,
   // external interrupt pins, asynchronous
   input wire [3:0] ext_irq_pin,
   // control outputs to the core
   output reg variable_latency,
   output reg nesting_allowed,
   output reg irq_open,
   output reg sw_trap_allowed,
   output reg [3:0] cpu_priority,
   output reg math_trap,
   output reg acc_trap,
   output reg [3:0] ext_irq_edge
);

   // address phase decode and pending data phase
   reg wr_pend;
   reg rd_pend;
   reg [7:0] acc_addr;
   wire take;
   assign take = hsel & htrans[1] & hready;

   // register bits
   reg var_lat;
   reg priority_level_msb;
   reg [2:0] cpu_status_word;
   reg nesting_block;
   reg acc_a_overflow_flag;
   reg acc_b_overflow_flag;
   reg acc_a_catastrophic_flag;
   reg acc_b_catastrophic_flag;
   reg acc_a_overflow_trap_en;
   reg acc_b_overflow_trap_en;
   reg catastrophic_trap_en;
   reg shift_error_flag;
   reg divide_zero_flag;
   reg arith_trap_flag;
   reg address_trap_flag;
   reg stack_trap_flag;
   reg oscillator_trap_flag;
   reg global_irq_enable;
   reg timed_disable_active;
   reg software_trap_enable;
   reg [3:0] ext_irq_polarity;
   reg nvm_addr_soft_trap_flag;
   reg dma_addr_soft_trap_flag;
   reg loop_stack_overflow_flag;
   reg aux_lock_loss_flag;
   reg soft_hard_trap_flag;

   // pin synchroniser and edge history
   reg [3:0] pin_meta;
   reg [3:0] pin_sync;
   reg [3:0] pin_prev;

   // per-register write strobes in the data phase
   wire wr_ccw;
   wire wr_tc1;
   wire wr_ic2;
   wire wr_sts;
   wire wr_hts;
   wire wr_csw;
   assign wr_ccw = wr_pend & (acc_addr == `SCTIC_OFS_CCW);
   assign wr_tc1 = wr_pend & (acc_addr == `SCTIC_OFS_TC1);
   assign wr_ic2 = wr_pend & (acc_addr == `SCTIC_OFS_IC2);
   assign wr_sts = wr_pend & (acc_addr == `SCTIC_OFS_STS);
   assign wr_hts = wr_pend & (acc_addr == `SCTIC_OFS_HTS);
   assign wr_csw = wr_pend & (acc_addr == `SCTIC_OFS_CSW);

   // trap qualification against the enables
   wire trap_ova;
   wire trap_ovb;
   wire trap_cova;
   wire trap_covb;
   wire trap_math;
   assign trap_ova = ev_acc_a_ovf & acc_a_overflow_trap_en;
   assign trap_ovb = ev_acc_b_ovf & acc_b_overflow_trap_en;
   assign trap_cova = ev_acc_a_cat & catastrophic_trap_en;
   assign trap_covb = ev_acc_b_cat & catastrophic_trap_en;
   assign trap_math = trap_ova | trap_ovb | trap_cova | trap_covb
      | ev_shift_err | ev_div_zero;

   // sticky flag: hardware set wins over a software write
   function sticky;
      input cur;
      input set;
      input wr;
      input wbit;
      begin
         if (set)
            sticky = 1'b1;
         else if (wr)
            sticky = wbit;
         else
            sticky = cur;
      end
   endfunction

   // edge select per polarity: 1 falling, 0 rising
   function edge_hit;
      input pol;
      input prev;
      input now;
      begin
         edge_hit = pol ? (prev & ~now) : (~prev & now);
      end
   endfunction

   // read data of the addressed register, unused bits zero
   function [31:0] rd_word;
      input [7:0] a;
      begin
         rd_word = `SCTIC_RST_WORD;
         case (a)
            `SCTIC_OFS_CCW: begin
               rd_word[`SCTIC_CCW_VAR] = var_lat;
               rd_word[`SCTIC_CCW_MSB] = priority_level_msb;
            end
            `SCTIC_OFS_TC1: begin
               rd_word[`SCTIC_TC1_NEST] = nesting_block;
               rd_word[`SCTIC_TC1_OVA] = acc_a_overflow_flag;
               rd_word[`SCTIC_TC1_OVB] = acc_b_overflow_flag;
               rd_word[`SCTIC_TC1_COVA] = acc_a_catastrophic_flag;
               rd_word[`SCTIC_TC1_COVB] = acc_b_catastrophic_flag;
               rd_word[`SCTIC_TC1_ACC_A_OVERFLOW_TRAP_EN] = acc_a_overflow_trap_en;
               rd_word[`SCTIC_TC1_ACC_B_OVERFLOW_TRAP_EN] = acc_b_overflow_trap_en;
               rd_word[`SCTIC_TC1_CATASTROPHIC_TRAP_EN] = catastrophic_trap_en;
               rd_word[`SCTIC_TC1_SHIFT] = shift_error_flag;
               rd_word[`SCTIC_TC1_DIV0] = divide_zero_flag;
               rd_word[`SCTIC_TC1_MATH] = arith_trap_flag;
               rd_word[`SCTIC_TC1_ADDR] = address_trap_flag;
               rd_word[`SCTIC_TC1_STACK] = stack_trap_flag;
               rd_word[`SCTIC_TC1_OSC] = oscillator_trap_flag;
            end
            `SCTIC_OFS_IC2: begin
               rd_word[`SCTIC_IC2_GIE] = global_irq_enable;
               rd_word[`SCTIC_IC2_TIMED_DISABLE_ACTIVE] = timed_disable_active;
               rd_word[`SCTIC_IC2_SWT] = software_trap_enable;
               rd_word[`SCTIC_IC2_POL_LSB+3:`SCTIC_IC2_POL_LSB] = ext_irq_polarity;
            end
            `SCTIC_OFS_STS: begin
               rd_word[`SCTIC_STS_NVM] = nvm_addr_soft_trap_flag;
               rd_word[`SCTIC_STS_DMA] = dma_addr_soft_trap_flag;
               rd_word[`SCTIC_STS_LOOP] = loop_stack_overflow_flag;
               rd_word[`SCTIC_STS_AUX] = aux_lock_loss_flag;
            end
            `SCTIC_OFS_HTS: begin
               rd_word[`SCTIC_HTS_SOFT_HARD_TRAP_FLAG] = soft_hard_trap_flag;
            end
            `SCTIC_OFS_CSW: begin
               rd_word[`SCTIC_CSW_IPL_LSB+2:`SCTIC_CSW_IPL_LSB] = cpu_status_word;
            end
            default: begin
               rd_word = `SCTIC_RST_WORD;
            end
         endcase
      end
   endfunction

   // ahb-lite slave: writes take no wait, reads one wait state
   always @(posedge mclk) begin
      if (!nrst) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         acc_addr <= 8'h00;
         hrdata <= `SCTIC_RST_WORD;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         wr_pend <= take & hwrite;
         rd_pend <= take & ~hwrite;
         if (take)
            acc_addr <= {haddr[7:2], 2'b00};
         hreadyout <= ~(take & ~hwrite);
         if (rd_pend)
            hrdata <= rd_word(acc_addr);
      end
   end

   // core control word and priority level
   always @(posedge mclk) begin
      if (!nrst) begin
         var_lat <= 1'b0;
         priority_level_msb <= 1'b0;
         cpu_status_word <= 3'h0;
      end else begin
         if (wr_ccw)
            var_lat <= hwdata[`SCTIC_CCW_VAR];
         // msb follows the loaded level, a write may only clear it
         if (ipl_load)
            priority_level_msb <= ipl_new[3];
         else if (wr_ccw & ~hwdata[`SCTIC_CCW_MSB])
            priority_level_msb <= 1'b0;
         // low priority bits ignore bus writes while nesting is blocked; a level load still sets them
         if (ipl_load)
            cpu_status_word <= ipl_new[2:0];
         else if (wr_csw & ~nesting_block)
            cpu_status_word <= hwdata[`SCTIC_CSW_IPL_LSB+2:`SCTIC_CSW_IPL_LSB];
      end
   end

   // trap control 1: enables and sticky trap flags
   always @(posedge mclk) begin
      if (!nrst) begin
         nesting_block <= 1'b0;
         acc_a_overflow_trap_en <= 1'b0;
         acc_b_overflow_trap_en <= 1'b0;
         catastrophic_trap_en <= 1'b0;
         acc_a_overflow_flag <= 1'b0;
         acc_b_overflow_flag <= 1'b0;
         acc_a_catastrophic_flag <= 1'b0;
         acc_b_catastrophic_flag <= 1'b0;
         shift_error_flag <= 1'b0;
         divide_zero_flag <= 1'b0;
         arith_trap_flag <= 1'b0;
         address_trap_flag <= 1'b0;
         stack_trap_flag <= 1'b0;
         oscillator_trap_flag <= 1'b0;
      end else begin
         if (wr_tc1) begin
            nesting_block <= hwdata[`SCTIC_TC1_NEST];
            acc_a_overflow_trap_en <= hwdata[`SCTIC_TC1_ACC_A_OVERFLOW_TRAP_EN];
            acc_b_overflow_trap_en <= hwdata[`SCTIC_TC1_ACC_B_OVERFLOW_TRAP_EN];
            catastrophic_trap_en <= hwdata[`SCTIC_TC1_CATASTROPHIC_TRAP_EN];
         end
         acc_a_overflow_flag <= sticky(acc_a_overflow_flag, trap_ova,
            wr_tc1, hwdata[`SCTIC_TC1_OVA]);
         acc_b_overflow_flag <= sticky(acc_b_overflow_flag, trap_ovb,
            wr_tc1, hwdata[`SCTIC_TC1_OVB]);
         acc_a_catastrophic_flag <= sticky(acc_a_catastrophic_flag, trap_cova,
            wr_tc1, hwdata[`SCTIC_TC1_COVA]);
         acc_b_catastrophic_flag <= sticky(acc_b_catastrophic_flag, trap_covb,
            wr_tc1, hwdata[`SCTIC_TC1_COVB]);
         shift_error_flag <= sticky(shift_error_flag, ev_shift_err,
            wr_tc1, hwdata[`SCTIC_TC1_SHIFT]);
         divide_zero_flag <= sticky(divide_zero_flag, ev_div_zero,
            wr_tc1, hwdata[`SCTIC_TC1_DIV0]);
         arith_trap_flag <= sticky(arith_trap_flag, trap_math,
            wr_tc1, hwdata[`SCTIC_TC1_MATH]);
         address_trap_flag <= sticky(address_trap_flag, ev_addr_err,
            wr_tc1, hwdata[`SCTIC_TC1_ADDR]);
         stack_trap_flag <= sticky(stack_trap_flag, ev_stack_err,
            wr_tc1, hwdata[`SCTIC_TC1_STACK]);
         oscillator_trap_flag <= sticky(oscillator_trap_flag, ev_osc_fail,
            wr_tc1, hwdata[`SCTIC_TC1_OSC]);
      end
   end

   // interrupt control 2: global enable, software trap, polarities
   always @(posedge mclk) begin
      if (!nrst) begin
         global_irq_enable <= `SCTIC_RST_GIE;
         software_trap_enable <= 1'b0;
         ext_irq_polarity <= 4'h0;
         timed_disable_active <= 1'b0;
      end else begin
         timed_disable_active <= timed_disable_in;
         if (wr_ic2) begin
            global_irq_enable <= hwdata[`SCTIC_IC2_GIE];
            software_trap_enable <= hwdata[`SCTIC_IC2_SWT];
            ext_irq_polarity <= hwdata[`SCTIC_IC2_POL_LSB+3:`SCTIC_IC2_POL_LSB];
         end
      end
   end

   // soft and hard trap status flags
   always @(posedge mclk) begin
      if (!nrst) begin
         nvm_addr_soft_trap_flag <= 1'b0;
         dma_addr_soft_trap_flag <= 1'b0;
         loop_stack_overflow_flag <= 1'b0;
         aux_lock_loss_flag <= 1'b0;
         soft_hard_trap_flag <= 1'b0;
      end else begin
         nvm_addr_soft_trap_flag <= sticky(nvm_addr_soft_trap_flag, ev_nvm_addr,
            wr_sts, hwdata[`SCTIC_STS_NVM]);
         dma_addr_soft_trap_flag <= sticky(dma_addr_soft_trap_flag, ev_dma_addr,
            wr_sts, hwdata[`SCTIC_STS_DMA]);
         loop_stack_overflow_flag <= sticky(loop_stack_overflow_flag, ev_loop_ovf,
            wr_sts, hwdata[`SCTIC_STS_LOOP]);
         aux_lock_loss_flag <= sticky(aux_lock_loss_flag, ev_aux_lock_loss,
            wr_sts, hwdata[`SCTIC_STS_AUX]);
         soft_hard_trap_flag <= sticky(soft_hard_trap_flag, ev_sw_hard_trap,
            wr_hts, hwdata[`SCTIC_HTS_SOFT_HARD_TRAP_FLAG]);
      end
   end

   // external pins: two-flop synchroniser then edge history
   always @(posedge mclk) begin
      if (!nrst) begin
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
         pin_prev <= 4'h0;
      end else begin
         pin_meta <= ext_irq_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // registered outputs to the core
   always @(posedge mclk) begin
      if (!nrst) begin
         variable_latency <= 1'b0;
         nesting_allowed <= 1'b1;
         irq_open <= 1'b0;
         sw_trap_allowed <= 1'b0;
         cpu_priority <= 4'h0;
         math_trap <= 1'b0;
         acc_trap <= 1'b0;
         ext_irq_edge <= 4'h0;
      end else begin
         variable_latency <= var_lat;
         nesting_allowed <= ~nesting_block;
         // traps bypass this gate, only interrupts are held off
         irq_open <= global_irq_enable & ~timed_disable_active;
         sw_trap_allowed <= software_trap_enable;
         cpu_priority <= {priority_level_msb, cpu_status_word};
         math_trap <= trap_math;
         acc_trap <= trap_ova | trap_ovb | trap_cova | trap_covb;
         ext_irq_edge[0] <= edge_hit(ext_irq_polarity[0], pin_prev[0], pin_sync[0]);
         ext_irq_edge[1] <= edge_hit(ext_irq_polarity[1], pin_prev[1], pin_sync[1]);
         ext_irq_edge[2] <= edge_hit(ext_irq_polarity[2], pin_prev[2], pin_sync[2]);
         ext_irq_edge[3] <= edge_hit(ext_irq_polarity[3], pin_prev[3], pin_sync[3]);
      end
   end

endmodule // sctic_top

/* src/sctic_map.vh */
// register map and field positions of the second core trap and interrupt control
`ifndef SCTIC_MAP_VH
`define SCTIC_MAP_VH

// register byte offsets, one aligned word each
`define SCTIC_OFS_CCW 8'h00
`define SCTIC_OFS_TC1 8'h04
`define SCTIC_OFS_IC2 8'h08
`define SCTIC_OFS_STS 8'h0C
`define SCTIC_OFS_HTS 8'h10
`define SCTIC_OFS_CSW 8'h14

// core_control_word fields
`define SCTIC_CCW_VAR 15
`define SCTIC_CCW_MSB 3

// trap_control_1 fields
`define SCTIC_TC1_NEST 15
`define SCTIC_TC1_OVA 14
`define SCTIC_TC1_OVB 13
`define SCTIC_TC1_COVA 12
`define SCTIC_TC1_COVB 11
`define SCTIC_TC1_ACC_A_OVERFLOW_TRAP_EN 10
`define SCTIC_TC1_ACC_B_OVERFLOW_TRAP_EN 9
`define SCTIC_TC1_CATASTROPHIC_TRAP_EN 8
`define SCTIC_TC1_SHIFT 7
`define SCTIC_TC1_DIV0 6
`define SCTIC_TC1_MATH 4
`define SCTIC_TC1_ADDR 3
`define SCTIC_TC1_STACK 2
`define SCTIC_TC1_OSC 1

// interrupt_control_2 fields
`define SCTIC_IC2_GIE 15
`define SCTIC_IC2_TIMED_DISABLE_ACTIVE 14
`define SCTIC_IC2_SWT 13
`define SCTIC_IC2_POL_LSB 0

// soft_trap_status and hard_trap_status fields
`define SCTIC_STS_NVM 8
`define SCTIC_STS_DMA 5
`define SCTIC_STS_LOOP 4
`define SCTIC_STS_AUX 0
`define SCTIC_HTS_SOFT_HARD_TRAP_FLAG 0

// cpu_status_word priority field, low bit position
`define SCTIC_CSW_IPL_LSB 5

// reset values
`define SCTIC_RST_GIE 1'b1
`define SCTIC_RST_WORD 32'h0000_0000

`endif

/* dv/sctic_core_model.sv */
// behavioural model of the core and trap sources facing the control block
`timescale 1ns/1ps
module sctic_core_model (
   // clock
   input logic mclk,
   // trap events, core state and external pins
   output logic [13:0] ev,
   output logic ipl_load,
   output logic [3:0] ipl_new,
   output logic timed_disable_in,
   output logic [3:0] ext_irq_pin
);
   // quiet state at time zero
   initial begin
      ev = 14'h0000;
      ipl_load = 1'h0;
      ipl_new = 4'h0;
      timed_disable_in = 1'h0;
      ext_irq_pin = 4'h0;
   end
   // one-cycle trap event pulse
   task pulse(input int i);
      ev[i] <= 1'h1;
      @(posedge mclk);
      ev[i] <= 1'h0;
   endtask
   // one-cycle priority level load
   task load_ipl(input logic [3:0] v);
      ipl_new <= v;
      ipl_load <= 1'h1;
      @(posedge mclk);
      ipl_load <= 1'h0;
   endtask
   // timed disable instruction state
   task set_timed_disable_active(input logic v);
      timed_disable_in <= v;
      @(posedge mclk);
   endtask
   // pins held well past the two-flop synchroniser
   task drive_pins(input logic [3:0] v);
      ext_irq_pin <= v;
      repeat (6) @(posedge mclk);
   endtask
endmodule // sctic_core_model

/* dv/sctic_top_monitor.sv */
// concurrent checks on the control block ports
`timescale 1ns/1ps
module sctic_monitor (
   // clock and reset
   input logic mclk,
   input logic nrst,
   // bus
   input logic hsel,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic hready,
   input logic [31:0] hrdata,
   input logic hreadyout,
   input logic hresp,
   // events and core state
   input logic ev_acc_a_ovf,
   input logic ev_acc_b_ovf,
   input logic ev_acc_a_cat,
   input logic ev_acc_b_cat,
   input logic ev_shift_err,
   input logic ev_div_zero,
   input logic ipl_load,
   input logic [3:0] ipl_new,
   input logic timed_disable_in,
   // control outputs
   input logic irq_open,
   input logic [3:0] cpu_priority,
   input logic math_trap,
   input logic acc_trap,
   input logic [3:0] ext_irq_edge
);
   logic rd_dph;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // marks the data phase of a taken read
   always @(posedge mclk) begin
      if (!nrst) begin
         rd_dph <= 1'h0;
      end else if (hready) begin
         rd_dph <= hsel && htrans[1] && !hwrite;
      end
   end
   sequence s_rd_req;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence s_rd_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   a_read_wait: assert property (s_rd_req |=> s_rd_wait)
      else $error("read data phase not one wait state");
   a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_resp_okay: assert property (!hresp)
      else $error("error response seen");
   a_upper_zero: assert property (rd_dph && hreadyout |-> hrdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_acc_cause: assert property (
      acc_trap |-> $past(ev_acc_a_ovf || ev_acc_b_ovf || ev_acc_a_cat || ev_acc_b_cat))
      else $error("accumulator trap without event");
   a_acc_math: assert property (acc_trap |-> math_trap)
      else $error("accumulator trap not a math trap");
   a_div_math: assert property (ev_div_zero |=> math_trap)
      else $error("divide by zero gave no math trap");
   a_shift_math: assert property (ev_shift_err |=> math_trap)
      else $error("shift error gave no math trap");
   a_prio_load: assert property (ipl_load |-> ##2 cpu_priority == $past(ipl_new, 2))
      else $error("priority level not loaded");
   a_timed_disable_active_block: assert property (timed_disable_in [*3] |-> !irq_open)
      else $error("interrupts open during timed disable");
   a_edge_single: assert property ((ext_irq_edge & $past(ext_irq_edge)) == 4'h0)
      else $error("edge pulse longer than one cycle");
endmodule // sctic_monitor

bind sctic_top sctic_monitor sctic_monitor_i (.*);

/* dv/tb_second_core_trap_interrupt_control.sv */
// self-checking bench of the trap and interrupt control block
`timescale 1ns/1ps
`include "sctic_map.vh"
module tb_second_core_trap_interrupt_control;
   logic mclk = 1'h0;
   logic nrst = 1'h0;
   logic hsel = 1'h0;
   logic hwrite = 1'h0;
   logic rd_dph = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rs = 32'h4C;
   logic [31:0] exp_q[$];
   logic [15:0] ev_mask [14] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090,
      16'h0050, 16'h0008, 16'h0004, 16'h0002, 16'h0100, 16'h0020, 16'h0010, 16'h0001, 16'h0001};
   wire [31:0] hrdata;
   wire [13:0] ev;
   wire [3:0] cpu_priority, ext_irq_edge, ipl_new, ext_irq_pin;
   wire hreadyout, hresp, variable_latency, nesting_allowed, irq_open, sw_trap_allowed;
   wire math_trap, acc_trap, ipl_load, timed_disable_in;
   int err_count = 0, cmp_count = 0, math_cnt = 0, acc_cnt = 0;
   int edge_cnt [4] = '{0, 0, 0, 0};

   sctic_top sctic_top_i (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ev_acc_a_ovf(ev[0]),
      .ev_acc_b_ovf(ev[1]), .ev_acc_a_cat(ev[2]), .ev_acc_b_cat(ev[3]), .ev_shift_err(ev[4]),
      .ev_div_zero(ev[5]), .ev_addr_err(ev[6]), .ev_stack_err(ev[7]), .ev_osc_fail(ev[8]),
      .ev_nvm_addr(ev[9]), .ev_dma_addr(ev[10]), .ev_loop_ovf(ev[11]),
      .ev_aux_lock_loss(ev[12]), .ev_sw_hard_trap(ev[13]), .ipl_load(ipl_load),
      .ipl_new(ipl_new), .timed_disable_in(timed_disable_in), .ext_irq_pin(ext_irq_pin),
      .variable_latency(variable_latency), .nesting_allowed(nesting_allowed),
      .irq_open(irq_open), .sw_trap_allowed(sw_trap_allowed), .cpu_priority(cpu_priority),
      .math_trap(math_trap), .acc_trap(acc_trap), .ext_irq_edge(ext_irq_edge));
   sctic_core_model sctic_core_model_i (.mclk(mclk), .ev(ev), .ipl_load(ipl_load),
      .ipl_new(ipl_new), .timed_disable_in(timed_disable_in), .ext_irq_pin(ext_irq_pin));

   // clock generator
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task chk_rd(input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch hrdata expected %h seen %h", e, g);
      end
   endtask
   task chk_out(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // single ahb-lite transfer; a read queues its expected word
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      if (!w) exp_q.push_back(d);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge mclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      do @(posedge mclk); while (hreadyout !== 1'h1);
   endtask
   // read data checker and pulse counters
   always @(posedge mclk) begin
      if (rd_dph && hreadyout === 1'h1) chk_rd(exp_q.pop_front(), hrdata);
      if (hreadyout === 1'h1) rd_dph <= hsel && htrans[1] && !hwrite;
      math_cnt += (math_trap === 1'h1);
      acc_cnt += (acc_trap === 1'h1);
      for (int i = 0; i < 4; i++) edge_cnt[i] += (ext_irq_edge[i] === 1'h1);
   end
   // watchdog
   initial begin
      repeat (6000) @(posedge mclk);
      err_count++;
      give_verdict();
   end
   // main sequence
   initial begin
      logic [31:0] r;
      logic [7:0] o;
      logic [3:0] v, p;
      int m, a;
      int e [4];
      repeat (2) @(posedge mclk);
      nrst <= 1'h1;
      repeat (2) @(posedge mclk);
      bus(0, `SCTIC_OFS_CCW, 32'h0);
      bus(0, `SCTIC_OFS_TC1, 32'h0);
      bus(0, `SCTIC_OFS_IC2, 32'h8000);
      bus(0, `SCTIC_OFS_STS, 32'h0);
      bus(0, `SCTIC_OFS_HTS, 32'h0);
      bus(0, 8'h18, 32'h0);
      chk_out("irq_open", 1, irq_open);
      chk_out("nesting_allowed", 1, nesting_allowed);
      bus(1, `SCTIC_OFS_CCW, 32'hFFFF);
      bus(0, `SCTIC_OFS_CCW, 32'h8000);
      bus(1, `SCTIC_OFS_HTS, 32'hFFFF);
      bus(0, `SCTIC_OFS_HTS, 32'h1);
      chk_out("variable_latency", 1, variable_latency);
      bus(1, `SCTIC_OFS_CCW, 32'h0);
      bus(1, `SCTIC_OFS_TC1, 32'h8000);
      repeat (2) @(posedge mclk);
      chk_out("variable_latency", 0, variable_latency);
      chk_out("nesting_allowed", 0, nesting_allowed);
      bus(1, `SCTIC_OFS_TC1, 32'h0);
      $display("test reset and access done");
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         v = {i[0], r[2:0]};
         sctic_core_model_i.load_ipl(v);
         repeat (2) @(posedge mclk);
         chk_out("cpu_priority", v, cpu_priority);
         bus(0, `SCTIC_OFS_CCW, {28'h0, v[3], 3'h0});
         bus(0, `SCTIC_OFS_CSW, {24'h0, v[2:0], 5'h0});
         bus(1, `SCTIC_OFS_CCW, 32'h0);
         bus(0, `SCTIC_OFS_CCW, 32'h0);
      end
      // status word priority bits: writable while nesting runs, locked while blocked
      bus(1, `SCTIC_OFS_CSW, 32'hE0);
      bus(0, `SCTIC_OFS_CSW, 32'hE0);
      bus(1, `SCTIC_OFS_TC1, 32'h8000);
      bus(1, `SCTIC_OFS_CSW, 32'h0);
      bus(0, `SCTIC_OFS_CSW, 32'hE0);
      chk_out("cpu_priority", 4'h7, cpu_priority);
      bus(1, `SCTIC_OFS_TC1, 32'h0);
      $display("test priority done");
      for (int i = 0; i < 14; i++) begin
         o = i < 9 ? `SCTIC_OFS_TC1 : (i < 13 ? `SCTIC_OFS_STS : `SCTIC_OFS_HTS);
         bus(1, `SCTIC_OFS_TC1, 32'h0700);
         bus(1, `SCTIC_OFS_STS, 32'h0);
         bus(1, `SCTIC_OFS_HTS, 32'h0);
         m = math_cnt;
         a = acc_cnt;
         sctic_core_model_i.pulse(i);
         repeat (8) @(posedge mclk);
         bus(0, o, {16'h0, ev_mask[i] | (i < 9 ? 16'h0700 : 16'h0)});
         chk_out("math_trap", i < 6, math_cnt - m);
         chk_out("acc_trap", i < 4, acc_cnt - a);
      end
      repeat (20) @(posedge mclk);
      bus(0, `SCTIC_OFS_HTS, 32'h1);
      bus(1, `SCTIC_OFS_TC1, 32'h0);
      a = acc_cnt;
      for (int i = 0; i < 4; i++) sctic_core_model_i.pulse(i);
      repeat (3) @(posedge mclk);
      bus(0, `SCTIC_OFS_TC1, 32'h0);
      chk_out("acc_trap", 0, acc_cnt - a);
      $display("test trap flags done");
      bus(1, `SCTIC_OFS_IC2, 32'h6000);
      bus(0, `SCTIC_OFS_IC2, 32'h2000);
      repeat (2) @(posedge mclk);
      chk_out("irq_open", 0, irq_open);
      chk_out("sw_trap_allowed", 1, sw_trap_allowed);
      m = math_cnt;
      sctic_core_model_i.pulse(4);
      repeat (3) @(posedge mclk);
      chk_out("math_trap", 1, math_cnt - m);
      bus(1, `SCTIC_OFS_IC2, 32'h8000);
      sctic_core_model_i.set_timed_disable_active(1'h1);
      repeat (4) @(posedge mclk);
      bus(0, `SCTIC_OFS_IC2, 32'hC000);
      chk_out("irq_open", 0, irq_open);
      chk_out("sw_trap_allowed", 0, sw_trap_allowed);
      sctic_core_model_i.set_timed_disable_active(1'h0);
      repeat (4) @(posedge mclk);
      chk_out("irq_open", 1, irq_open);
      for (int k = 0; k < 2; k++) begin
         r = rnd();
         p = k == 0 ? r[3:0] : ~p;
         bus(1, `SCTIC_OFS_IC2, {16'h0, 12'h800, p});
         bus(0, `SCTIC_OFS_IC2, {16'h0, 12'h800, p});
         e = edge_cnt;
         sctic_core_model_i.drive_pins(4'hF);
         for (int i = 0; i < 4; i++) chk_out("edge_rise", !p[i], edge_cnt[i] - e[i]);
         e = edge_cnt;
         sctic_core_model_i.drive_pins(4'h0);
         for (int i = 0; i < 4; i++) chk_out("edge_fall", p[i], edge_cnt[i] - e[i]);
      end
      $display("test control and pins done");
      repeat (2) @(posedge mclk);
      give_verdict();
   end
endmodule // tb_second_core_trap_interrupt_control
